// >>> design/ssc_pkg.sv
package ssc_pkg;

    // ***********************************************
    // sizes
    // ***********************************************
    localparam int CHANNELS = 8;
    localparam int PWM_A_BIT = 4; // output five
    localparam int PWM_B_BIT = 5; // output six

    // ***********************************************
    // timing
    // ***********************************************
    localparam int CLK_MHZ = 100;
    localparam int FAULT_DELAY_US = 300;
    // least time: whole microseconds times whole MHz needs no rounding
    localparam int FAULT_DELAY_CYC = FAULT_DELAY_US * CLK_MHZ;

    // ***********************************************
    // synchroniser vector layout
    // ***********************************************
    localparam int SY_OPEN = 0;
    localparam int SY_OCUR = 8;
    localparam int SY_OTMP = 16;
    localparam int SY_PWMB = 24;
    localparam int SY_PWMA = 25;
    localparam int SY_OVLT = 26;
    localparam int SY_EN = 27;
    localparam int SY_CS = 28;
    localparam int SY_W = 29;

    // ***********************************************
    // reset values
    // ***********************************************
    localparam logic [SY_W-1:0] SYNC_RST = 29'h10000000; // chip select idle
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] FAULT_RST = 8'h00;
    localparam logic [7:0] SREG_RST = 8'h00;

endpackage

// >>> design/ssc_top.sv
`timescale 1ns/10ps
// Summary of operation
// - status out is undriven while chip select high, driven while low.
// - status bit is 1 for faulted output, 0 for normal output.
// - first rising sclk shows output eight status, then next lower each.
// - shift path is first-in first-out, both words msb first.
// - outputs on and fault detection only while enable is high.
// - outputs on before enable fell turn on again when it returns.
// - outputs five and six are on when command bit or pwm pin high.
// - reset holds every driver off and all logic in reset.
// - command bit 0 turns output off, 1 turns it on.
// - rising chip select copies shift register into command latch.
// - daisy chain passes shifted input bits on to status output.
// - status word shifts out while command word shifts in.
// - 16-bit check returns status then first byte; second byte commands.
// - overtemperature turns off only its output and sets its fault bit.
// - output returns after overtemperature unless commanded off meanwhile.
// - overvoltage turns all outputs off; recovery restores commands.
// - falling chip select freezes fault status; first falling sclk loads it into the shift register.
// - input sampled on falling sclk, output shifted on rising sclk.
// - sclk and data input are ignored while chip select is high.
// - rising chip select restarts delay; open load accepted after it.
module ssc_top #(
    parameter int FAULT_DELAY_CYCLES = ssc_pkg::FAULT_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic serial_command_in,
    output logic serial_status_out,
    output logic serial_status_oe,
    input wire logic direct_pwm_input_a,
    input wire logic direct_pwm_input_b,
    input wire logic enable_in,
    input wire logic load_supply_overvoltage,
    input wire logic [ssc_pkg::CHANNELS-1:0] over_temp,
    input wire logic [ssc_pkg::CHANNELS-1:0] over_current,
    input wire logic [ssc_pkg::CHANNELS-1:0] off_open_load,
    output logic [ssc_pkg::CHANNELS-1:0] drive_on,
    output logic [ssc_pkg::CHANNELS-1:0] command_word,
    output logic [ssc_pkg::CHANNELS-1:0] fault_status_register
);
    import ssc_pkg::*;

    localparam int TMR_W = $clog2(FAULT_DELAY_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(FAULT_DELAY_CYCLES);
    localparam logic [TMR_W-1:0] TMR_ZERO = '0;
    localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

    // ***********************************************
    // link side, clocked by sclk
    // ***********************************************

    logic [7:0] sreg;
    logic [7:0] next_sreg;
    logic [7:0] shift_src;
    logic loaded;
    logic next_loaded;
    logic next_status_out;
    logic frame_rst_b;
    logic [7:0] status_snap;

    // frame flags clear whenever chip select is high or on reset
    assign frame_rst_b = rst_b & ~cs_b;

    // rising edge presents msb: snapshot first, shift register after
    always_comb begin
        next_loaded = 1'b1;
        if (loaded) begin
            next_status_out = sreg[7];
        end else begin
            next_status_out = status_snap[7];
        end
    end

    // status output flop, launched on rising sclk
    always_ff @(posedge sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            serial_status_out <= 1'b0;
        end else begin
            serial_status_out <= next_status_out;
        end
    end

    // first falling edge of a frame seeds the shift register from status
    always_ff @(negedge sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            loaded <= 1'b0;
        end else begin
            loaded <= next_loaded;
        end
    end

    // falling edge shifts data in at lsb, status moves up to msb
    always_comb begin
        shift_src = loaded ? sreg : status_snap;
        if (cs_b) begin
            next_sreg = sreg;
        end else begin
            next_sreg = {shift_src[6:0], serial_command_in};
        end
    end

    // shift register keeps its word across idle time for the latch
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            sreg <= SREG_RST;
        end else begin
            sreg <= next_sreg;
        end
    end

    // ***********************************************
    // control side, clocked by clk
    // ***********************************************

    logic [SY_W-1:0] sync_raw;
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic cs_prev;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic [7:0] fault;
    logic [7:0] next_fault;
    logic [7:0] next_snap;
    logic [7:0] next_drive;
    logic next_oe;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] next_timer;
    logic cs_rise;
    logic cs_fall;
    logic en_s;
    logic ovlt_s;
    logic [7:0] eff;
    logic [7:0] fault_set;
    logic [7:0] drive_now;

    // asynchronous pins gathered for the two-stage synchroniser
    assign sync_raw = {cs_b, enable_in, load_supply_overvoltage,
                       direct_pwm_input_a, direct_pwm_input_b,
                       over_temp, over_current, off_open_load};

    // chip select edges seen from the second stage only
    assign cs_rise = sync2[SY_CS] & ~cs_prev;
    assign cs_fall = ~sync2[SY_CS] & cs_prev;
    assign en_s = sync2[SY_EN];
    assign ovlt_s = sync2[SY_OVLT];

    // per output command merge, drive and fault detection
    generate
        for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
            logic pwm;
            if (i == PWM_A_BIT) begin : g_pa
                assign pwm = sync2[SY_PWMA];
            end else if (i == PWM_B_BIT) begin : g_pb
                assign pwm = sync2[SY_PWMB];
            end else begin : g_np
                assign pwm = 1'b0;
            end
            // serial bit or direct pin turns the output on
            assign eff[i] = cmd[i] | pwm;
            // enable, overvoltage and own overtemperature gate the drive
            assign drive_now[i] = eff[i] & en_s & ~ovlt_s
                                  & ~sync2[SY_OTMP+i];
            // overtemperature on or off, overcurrent while on, open load after the delay while off
            assign fault_set[i] = en_s & (sync2[SY_OTMP+i]
                | (eff[i] & sync2[SY_OCUR+i])
                | (~eff[i] & sync2[SY_OPEN+i] & (timer == TMR_ZERO)));
        end
    endgenerate

    // next values of the control side
    always_comb begin
        next_cmd = cmd;
        next_snap = status_snap;
        next_timer = timer;
        next_oe = ~sync2[SY_CS];
        next_drive = drive_now;
        if (cs_rise) begin
            next_cmd = sreg;
            next_timer = TMR_LOAD;
        end else if (timer != TMR_ZERO) begin
            next_timer = timer - TMR_ONE;
        end
        // snapshot follows faults while idle, frozen through a frame
        if (sync2[SY_CS]) begin
            next_snap = fault | fault_set;
        end
        // reported bits drop at frame start; a new event wins
        if (cs_fall) begin
            next_fault = fault_set;
        end else begin
            next_fault = fault | fault_set;
        end
    end

    // control side registers, frozen while ce is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
            cs_prev <= 1'b1;
            cmd <= CMD_RST;
            fault <= FAULT_RST;
            status_snap <= FAULT_RST;
            timer <= TMR_ZERO;
            drive_on <= CMD_RST;
            serial_status_oe <= 1'b0;
            command_word <= CMD_RST;
            fault_status_register <= FAULT_RST;
        end else if (ce) begin
            sync1 <= sync_raw;
            sync2 <= sync1;
            cs_prev <= sync2[SY_CS];
            cmd <= next_cmd;
            fault <= next_fault;
            status_snap <= next_snap;
            timer <= next_timer;
            drive_on <= next_drive;
            serial_status_oe <= next_oe;
            command_word <= next_cmd;
            fault_status_register <= next_fault;
        end
    end

endmodule

// >>> tb/ssc_monitor.sv
`timescale 1ns/10ps
// pin-level watch on the switch block
module ssc_monitor (
    input wire logic clk, rst_b, cs_b, serial_status_out, serial_status_oe,
    input wire logic direct_pwm_input_a, direct_pwm_input_b, enable_in,
    input wire logic load_supply_overvoltage,
    input wire logic [7:0] over_temp, drive_on, command_word,
    input wire logic [7:0] fault_status_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // gating inputs quiet long enough to pass the synchronisers
    sequence s_calm;
        (enable_in && !load_supply_overvoltage && over_temp == 8'h00 &&
         !direct_pwm_input_a && !direct_pwm_input_b)[*5];
    endsequence
    property p_rst; !$past(rst_b) |-> drive_on == 8'h00; endproperty
    property p_idle; cs_b[*5] |-> !serial_status_oe && !serial_status_out;
    endproperty
    property p_sel; !cs_b[*5] |-> serial_status_oe; endproperty
    property p_en; !enable_in[*5] |-> drive_on == 8'h00; endproperty
    property p_ovl; load_supply_overvoltage[*5] |-> drive_on == 8'h00;
    endproperty
    property p_hot; (drive_on & over_temp & $past(over_temp) &
        $past(over_temp, 2) & $past(over_temp, 3)) == 8'h00; endproperty
    property p_drv; s_calm |-> drive_on == $past(command_word); endproperty
    property p_pwm; (direct_pwm_input_a && enable_in && !over_temp[4] &&
        !load_supply_overvoltage)[*5] |-> drive_on[4]; endproperty
    property p_flt; (enable_in && over_temp[0])[*5] |->
        fault_status_register[0]; endproperty
    a_rst: assert property (p_rst) else $error("drive after reset");
    a_idle: assert property (p_idle) else $error("status driven");
    a_sel: assert property (p_sel) else $error("status undriven");
    a_en: assert property (p_en) else $error("on while disabled");
    a_ovl: assert property (p_ovl) else $error("on in overvolt");
    a_hot: assert property (p_hot) else $error("hot output on");
    a_drv: assert property (p_drv) else $error("drive vs command");
    a_pwm: assert property (p_pwm) else $error("pwm not ored");
    a_flt: assert property (p_flt) else $error("fault bit clear");
endmodule

bind ssc_top ssc_monitor mon (.clk, .rst_b, .cs_b, .serial_status_out,
    .serial_status_oe, .direct_pwm_input_a, .direct_pwm_input_b, .enable_in,
    .load_supply_overvoltage, .over_temp, .drive_on, .command_word,
    .fault_status_register);

// >>> tb/ssc_spi_master.sv
`timescale 1ns/10ps
// controller side of the serial link, 80 ns clock only within frames
module ssc_spi_master (
    output logic sclk,
    output logic cs_b,
    output logic mosi,
    input wire logic miso
);
    // idle link
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end
    // one frame of n bits, msb first, clock low at select edges
    task automatic xfer(input int n, input logic [15:0] d,
        output logic [15:0] q);
        q = 16'h0000;
        #3 cs_b <= 1'b0;
        #120;
        for (int i = n - 1; i >= 0; i--) begin
            mosi <= d[i];
            sclk <= 1'b1;
            #40 q = {q[14:0], miso};
            sclk <= 1'b0;
            #40;
        end
        #20 cs_b <= 1'b1;
        mosi <= ~mosi; // stale data line flips once deselected
        #100;
    endtask
endmodule

// >>> tb/ssc_tb_top.sv
`timescale 1ns/10ps
module ssc_tb_top;
    import ssc_pkg::*;
    logic clk, rst_b, ce, pwm_a, pwm_b, en, ovlt, so, oe, sclk, cs_b, mosi;
    logic [7:0] hot, cur, open_ld, drv, cmd, flt;
    logic [15:0] q;
    wire miso = oe ? so : 1'bz;
    int err_count = 0;
    int num_checks = 0;
    ssc_top #(.FAULT_DELAY_CYCLES(20)) DUT (.clk, .rst_b, .ce, .sclk, .cs_b,
        .serial_command_in(mosi), .serial_status_out(so),
        .serial_status_oe(oe), .direct_pwm_input_a(pwm_a),
        .direct_pwm_input_b(pwm_b), .enable_in(en),
        .load_supply_overvoltage(ovlt), .over_temp(hot), .over_current(cur),
        .off_open_load(open_ld), .drive_on(drv), .command_word(cmd),
        .fault_status_register(flt));
    ssc_spi_master M (.sclk, .cs_b, .mosi, .miso);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task wclk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // hot and open-load faults, overcurrent on an off output left unreported, then recovery
    task t_fault;
        M.xfer(8, 16'h0001, q);
        wclk(30);
        hot <= 8'h01;
        open_ld <= 8'h80;
        cur <= 8'h02;
        wclk(8);
        chk(drv, 8'h00);
        M.xfer(8, 16'h0001, q);
        chk(q, 16'h0081);
        @(posedge clk);
        hot <= 8'h00;
        open_ld <= 8'h00;
        cur <= 8'h00;
        wclk(30);
        chk(drv, 8'h01);
    endtask
    // pwm pins, enable and overvoltage gating
    task t_gate;
        pwm_a <= 1'b1;
        pwm_b <= 1'b1;
        wclk(6);
        chk(drv, 8'hF3);
        en <= 1'b0;
        wclk(6);
        chk(drv, 8'h00);
        en <= 1'b1;
        wclk(6);
        chk(drv, 8'hF3);
        ovlt <= 1'b1;
        wclk(6);
        chk(drv, 8'h00);
        ovlt <= 1'b0;
        wclk(6);
        chk(drv, 8'hF3);
    endtask
    // system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // main sequence
    initial begin
        {rst_b, pwm_a, pwm_b, ovlt, hot, cur, open_ld} = '0;
        ce = 1'b1;
        en = 1'b1;
        wclk(10);
        rst_b <= 1'b1;
        wclk(4);
        chk(drv, 8'h00);
        M.xfer(8, 16'h00A5, q);
        wclk(6);
        chk(q, 16'h0000);
        chk(cmd, 8'hA5);
        chk(drv, 8'hA5);
        t_fault;
        M.xfer(16, 16'h3CC3, q);
        wclk(6);
        chk(q, 16'h813C);
        chk(cmd, 8'hC3);
        t_gate;
        print_verdict;
    end
    // watchdog
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule
